// ===== design/pscm_core.sv
// return stack, pointer, loop registers, vector decision and mode register
`timescale 1ns/1ps
module pscm_core #(
  parameter int STOP_LONG = pscm_pkg::STOP_LONG_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire pscm_pkg::pscm_op_t op,
  input wire logic op_valid,
  input wire pscm_pkg::pscm_ctx_t ctx_in,
  input wire pscm_pkg::pscm_loop_t loop_in,
  input wire logic loop_abort,
  input wire logic vec_valid,
  input wire logic vec_word0_call,
  input wire logic vec_word1_call,
  input wire logic vec_word0_flow,
  input wire logic vec_word1_flow,
  input wire logic ss_wr_hi,
  input wire logic ss_wr_lo,
  input wire logic [15:0] ss_wdata,
  input wire logic sp_wr,
  input wire logic [5:0] sp_wdata,
  input wire logic omr_wr,
  input wire logic [4:0] omr_wdata,
  input wire logic boot_done,
  input wire logic chip_mode_lo,
  input wire logic chip_mode_hi,
  input wire logic [15:0] prog_addr,
  input wire logic [15:0] xdata_addr,
  input wire logic [15:0] ydata_addr,
  input wire logic stop_exit,
  input wire logic bus_pin_in,
  input wire logic bus_pin_drive,
  output logic [5:0] stack_top_pointer,
  output logic [4:0] operating_mode_reg,
  output logic [15:0] stack_upper_half,
  output logic [15:0] stack_lower_half,
  output pscm_pkg::pscm_ctx_t ctx_out,
  output logic restore_pc,
  output logic restore_sr,
  output pscm_pkg::pscm_loop_t loop_regs,
  output logic long_irq,
  output logic fast_irq,
  output logic [15:0] reset_vector,
  output pscm_pkg::pscm_map_t prog_map,
  output pscm_pkg::pscm_map_t xdata_map,
  output pscm_pkg::pscm_map_t ydata_map,
  output logic stop_wake,
  output logic bus_request_in,
  output logic wait_request_in,
  output logic bus_grant_out,
  output logic bus_strobe_out
);
  import pscm_pkg::*;

  localparam int SW = $clog2(STOP_LONG + 2);
  localparam logic [SW-1:0] LONG_C = SW'(STOP_LONG);
  localparam logic [SW-1:0] SHORT_C = SW'(STOP_SHORT_CYC);

  // [R02] dedicated stack memory
  logic [ENTRY_W-1:0] ctx_mem [1:STACK_DEPTH];
  logic [ENTRY_W-1:0] loop_mem [1:STACK_DEPTH];
  logic [SW-1:0] stop_cnt;
  logic stop_run;
  logic mode_loaded;
  logic pin_s1, pin_s2, cm_lo_s1, cm_lo_s2, cm_hi_s1, cm_hi_s2;

  function automatic pscm_map_t data_map(input logic [15:0] a,
                                         input logic de, input logic is_x);
    if (a <= DATA_RAM_TOP)
      return PSCM_MAP_RAM;
    else if (de && a <= DATA_ROM_TOP)
      return PSCM_MAP_ROM;
    else if (is_x && a >= PERIPH_BASE)
      return PSCM_MAP_PERIPH;
    else
      return PSCM_MAP_EXT;
  endfunction

  wire [PTR_W-1:0] ptr = stack_top_pointer[PTR_W-1:0];
  wire sp_empty = (ptr == '0);
  wire sp_full = (ptr == PTR_FULL);
  // [R07] call in either vector word makes a long interrupt
  wire vec_long = vec_valid && (vec_word0_call || vec_word1_call);
  // [R08] no flow change means fast, no push
  wire vec_fast = vec_valid && !vec_long
                  && !vec_word0_flow && !vec_word1_flow;
  wire is_push = (op_valid && (op == PSCM_OP_CALL || op == PSCM_OP_LOOP))
                 || vec_long;
  wire is_pop = op_valid && (op == PSCM_OP_RTS || op == PSCM_OP_RTI
                || op == PSCM_OP_LOOPEND) || loop_abort;
  wire [PTR_W-1:0] ptr_inc = ptr + 4'h1;
  wire [PTR_W-1:0] ptr_dec = ptr - 4'h1;
  wire [1:0] chip_mode = {operating_mode_reg[OMR_MB_BIT],
                          operating_mode_reg[OMR_MA_BIT]};
  wire de_bit = operating_mode_reg[OMR_DE_BIT];
  wire ea_bit = operating_mode_reg[OMR_EA_BIT];
  // [R14] reset vector from chip mode
  wire [15:0] next_vec = (chip_mode == MODE_EXTV) ? VEC_HIGH : VEC_LOW;
  // [R15] program space decode
  wire pscm_map_t next_pmap =
    (chip_mode != MODE_NORAM && prog_addr <= PROG_INT_TOP) ?
    PSCM_MAP_RAM : PSCM_MAP_EXT;
  // [R16] [R17] data space decode
  wire pscm_map_t next_xmap = data_map(xdata_addr, de_bit, 1'b1);
  wire pscm_map_t next_ymap = data_map(ydata_addr, de_bit, 1'b0);
  // [R18] stop exit delay select
  // one less, since the wake pulse itself takes the last cycle
  wire [SW-1:0] stop_load = operating_mode_reg[OMR_SD_BIT] ?
                            SHORT_C - SW'(1) : LONG_C - SW'(1);

  always_ff @(posedge sys_clk) begin
    pin_s1 <= bus_pin_in;
    pin_s2 <= pin_s1;
    cm_lo_s1 <= chip_mode_lo;
    cm_lo_s2 <= cm_lo_s1;
    cm_hi_s1 <= chip_mode_hi;
    cm_hi_s2 <= cm_hi_s1;
  end

  // [R10] [R11] [R21] pointer with status flags
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stack_top_pointer <= 6'h00;
    end else if (sp_wr) begin
      stack_top_pointer <= sp_wdata;
    end else if (is_push) begin
      if (sp_full)
        stack_top_pointer[SP_SE_BIT] <= 1'b1;
      else
        stack_top_pointer[PTR_W-1:0] <= ptr_inc;
    end else if (is_pop) begin
      if (sp_empty)
        stack_top_pointer[SP_UF_BIT] <= 1'b1;
      else
        stack_top_pointer[PTR_W-1:0] <= ptr_dec;
    end
  end

  // [R03] [R06] [R01] [R20] push context and loop state
  always_ff @(posedge sys_clk) begin
    if (is_push && !sp_full && !sp_wr) begin
      ctx_mem[ptr_inc] <= ctx_in;
      // old loop state is saved so a nested end restores the outer loop
      loop_mem[ptr_inc] <= loop_regs;
    end else if (!sp_empty) begin
      // [R09] halves write independently
      if (ss_wr_hi)
        ctx_mem[ptr][31:16] <= ss_wdata;
      if (ss_wr_lo)
        ctx_mem[ptr][15:0] <= ss_wdata;
    end
  end

  // [R01] [R20] loop registers load at start, restore at end or abort
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      loop_regs <= '0;
    end else if (op_valid && op == PSCM_OP_LOOP && !sp_full) begin
      loop_regs <= loop_in;
    end else if ((loop_abort || (op_valid && op == PSCM_OP_LOOPEND))
                 && !sp_empty) begin
      loop_regs <= loop_mem[ptr];
    end
  end

  // [R04] [R05] pop restores fetch pointer, status only on rti
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctx_out <= '0;
      restore_pc <= 1'b0;
      restore_sr <= 1'b0;
    end else begin
      ctx_out <= sp_empty ? '0 : ctx_mem[ptr];
      restore_pc <= is_pop && !sp_empty && op_valid
                    && (op == PSCM_OP_RTS || op == PSCM_OP_RTI);
      restore_sr <= is_pop && !sp_empty && op_valid && op == PSCM_OP_RTI;
    end
  end

  // [R09] halves read of top entry
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stack_upper_half <= 16'h0000;
      stack_lower_half <= 16'h0000;
    end else begin
      stack_upper_half <= sp_empty ? 16'h0000 : ctx_mem[ptr][31:16];
      stack_lower_half <= sp_empty ? 16'h0000 : ctx_mem[ptr][15:0];
    end
  end

  // [R12] [R13] mode register: cleared at reset, pins on the first edge after, else explicit writes or bootstrap handover
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      operating_mode_reg <= 5'h00;
      mode_loaded <= 1'b0;
    end else if (!mode_loaded) begin
      // pins are sampled just after release so the sync chain settles
      operating_mode_reg[OMR_MA_BIT] <= cm_lo_s2;
      operating_mode_reg[OMR_MB_BIT] <= cm_hi_s2;
      mode_loaded <= 1'b1;
    end else if (omr_wr) begin
      operating_mode_reg <= omr_wdata;
    end else if (boot_done && chip_mode == MODE_BOOT) begin
      // [R14] bootstrap hands over to mode two
      operating_mode_reg[OMR_MB_BIT] <= 1'b1;
      operating_mode_reg[OMR_MA_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reset_vector <= VEC_LOW;
      prog_map <= PSCM_MAP_EXT;
      xdata_map <= PSCM_MAP_EXT;
      ydata_map <= PSCM_MAP_EXT;
      long_irq <= 1'b0;
      fast_irq <= 1'b0;
    end else begin
      reset_vector <= next_vec;
      prog_map <= next_pmap;
      xdata_map <= next_xmap;
      ydata_map <= next_ymap;
      long_irq <= vec_long;
      fast_irq <= vec_fast;
    end
  end

  // [R18] wake-up counter
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      stop_cnt <= '0;
      stop_run <= 1'b0;
      stop_wake <= 1'b0;
    end else begin
      stop_wake <= 1'b0;
      if (stop_exit && !stop_run) begin
        stop_cnt <= stop_load;
        stop_run <= 1'b1;
      end else if (stop_run) begin
        if (stop_cnt <= SW'(1)) begin
          stop_run <= 1'b0;
          stop_wake <= 1'b1;
        end else begin
          stop_cnt <= stop_cnt - SW'(1);
        end
      end
    end
  end

  // [R19] bus pin function swap
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bus_request_in <= 1'b0;
      wait_request_in <= 1'b0;
      bus_grant_out <= 1'b0;
      bus_strobe_out <= 1'b0;
    end else begin
      bus_request_in <= !ea_bit && pin_s2;
      wait_request_in <= ea_bit && pin_s2;
      bus_grant_out <= !ea_bit && bus_pin_drive;
      bus_strobe_out <= ea_bit && bus_pin_drive;
    end
  end
endmodule

// ===== design/pscm_pkg.sv
// shared constants and types for the program stack and mode control block
// How it works
// [R01] loop end address pushed at loop start, popped at loop end or abort
// [R02] return stack is a private memory of 15 entries of 32 bits
// [R03] call or long interrupt pushes fetch pointer and status word together
// [R04] subroutine return pops and restores only the fetch pointer
// [R05] interrupt return pops and restores fetch pointer and status word
// [R06] loop start also saves loop count and loop end address
// [R07] vector word that is a call makes the service a long interrupt
// [R08] neither vector word changing flow means fast interrupt, no push
// [R09] each stack entry reads and writes as upper and lower 16-bit halves
// [R10] 6-bit stack top pointer holds position and underflow/empty/full/overflow
// [R11] pointer moves implicitly and is readable, writable by control move
// [R12] mode register changes only on reset or explicit writes; the code also changes it on bootstrap handover (boot_done)
// [R13] reset loads chip mode from pins, clears rom, stop and access bits
// [R14] chip mode picks reset vector; bootstrap mode then becomes mode two
// [R15] modes 0 and 2 map low program space internal; mode 3 all external
// [R16] rom off: low data internal, x top region peripherals, rest external
// [R17] rom on: adds internal rom region, external starts higher
// [R18] stop delay select picks long or short wake-up delay
// [R19] external access select swaps bus request/grant for wait/strobe
// [R20] loop count is 16 bits, pushed at loop start, popped at end
// [R21] push on full sets overflow, pop on empty sets underflow
package pscm_pkg;
  localparam int STACK_DEPTH = 15;
  localparam int ENTRY_W = 32;
  localparam int HALF_W = 16;
  localparam int SP_W = 6;
  localparam int PTR_W = 4;
  localparam logic [PTR_W-1:0] PTR_FULL = 4'hf;
  localparam int SP_UF_BIT = 5;
  localparam int SP_SE_BIT = 4;
  localparam int OMR_W = 5;
  localparam int OMR_MA_BIT = 0;
  localparam int OMR_MB_BIT = 1;
  localparam int OMR_DE_BIT = 2;
  localparam int OMR_SD_BIT = 3;
  localparam int OMR_EA_BIT = 4;
  localparam logic [1:0] MODE_INT = 2'h0;
  localparam logic [1:0] MODE_BOOT = 2'h1;
  localparam logic [1:0] MODE_EXTV = 2'h2;
  localparam logic [1:0] MODE_NORAM = 2'h3;
  localparam logic [15:0] VEC_LOW = 16'h0000;
  localparam logic [15:0] VEC_HIGH = 16'he000;
  localparam logic [15:0] PROG_INT_TOP = 16'h01ff;
  localparam logic [15:0] DATA_RAM_TOP = 16'h00ff;
  localparam logic [15:0] DATA_ROM_TOP = 16'h01ff;
  localparam logic [15:0] PERIPH_BASE = 16'hffc0;
  localparam int STOP_LONG_CYC = 65545;
  localparam int STOP_SHORT_CYC = 17;
  typedef enum logic [2:0] {
    PSCM_OP_NONE, PSCM_OP_CALL, PSCM_OP_RTS, PSCM_OP_RTI,
    PSCM_OP_LOOP, PSCM_OP_LOOPEND, PSCM_OP_REP
  } pscm_op_t;
  typedef enum logic [1:0] {
    PSCM_MAP_EXT, PSCM_MAP_RAM, PSCM_MAP_ROM, PSCM_MAP_PERIPH
  } pscm_map_t;
  typedef struct packed {
    logic [15:0] fetch_pointer;
    logic [15:0] status_word;
  } pscm_ctx_t;
  typedef struct packed {
    logic [15:0] loop_count;
    logic [15:0] loop_end_address;
  } pscm_loop_t;
endpackage

// ===== tb/pscm_bus_partner.sv
// far-side bus master that raises the shared request pin
`timescale 1ns/1ps
module pscm_bus_partner (
  input wire logic sys_clk,
  input wire logic want,
  output logic bus_pin_in
);
  always_ff @(posedge sys_clk) bus_pin_in <= want;
endmodule

// ===== tb/pscm_checker.sv
// concurrent checks on stack, vector and mode outputs
`timescale 1ns/1ps
module pscm_checker #(parameter int STOP_LONG = 40) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire pscm_pkg::pscm_op_t op,
  input wire logic op_valid,
  input wire logic sp_wr,
  input wire logic omr_wr,
  input wire logic boot_done,
  input wire logic vec_valid,
  input wire logic vec_word0_call,
  input wire logic vec_word1_call,
  input wire logic vec_word0_flow,
  input wire logic vec_word1_flow,
  input wire logic stop_exit,
  input wire logic [5:0] stack_top_pointer,
  input wire logic [4:0] operating_mode_reg,
  input wire logic restore_pc,
  input wire logic restore_sr,
  input wire logic long_irq,
  input wire logic fast_irq,
  input wire logic [15:0] reset_vector,
  input wire logic stop_wake
);
  import pscm_pkg::*;
  logic rst_d;
  wire [3:0] ptr = stack_top_pointer[3:0];
  wire take = op_valid && !sp_wr;
  wire call_w = vec_word0_call || vec_word1_call;
  wire flow_w = call_w || vec_word0_flow || vec_word1_flow;
  wire [1:0] md = operating_mode_reg[1:0];
  // pins load on the first edge out of reset, so skip it
  always_ff @(posedge sys_clk) rst_d <= srst;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence push_s; take && op == PSCM_OP_CALL; endsequence
  sequence pop_s(pscm_op_t o); take && op == o && ptr != 4'h0; endsequence
  sequence mode_steady; $stable(operating_mode_reg) [*3]; endsequence
  AST_CALL_PUSH: assert property (push_s ##0 ptr != PTR_FULL
    |=> ptr == $past(ptr) + 4'h1) else $error("call push");
  AST_RTS_PC: assert property (pop_s(PSCM_OP_RTS)
    |=> restore_pc && !restore_sr) else $error("rts restore");
  AST_RTI_BOTH: assert property (pop_s(PSCM_OP_RTI)
    |=> restore_pc && restore_sr) else $error("rti restore");
  AST_OVERFLOW: assert property (push_s ##0 ptr == PTR_FULL
    |=> stack_top_pointer[SP_SE_BIT] && ptr == PTR_FULL) else $error("ovf");
  AST_LONG_IRQ: assert property (vec_valid && call_w
    |=> long_irq && !fast_irq) else $error("long irq");
  AST_FAST_IRQ: assert property (vec_valid && !flow_w
    |=> fast_irq && !long_irq) else $error("fast irq");
  AST_MODE_HOLD: assert property (!omr_wr && !boot_done && !rst_d
    |=> $stable(operating_mode_reg)) else $error("mode changed");
  AST_VECTOR: assert property (mode_steady ##0 md != MODE_BOOT
    |-> reset_vector == (md == MODE_EXTV ? VEC_HIGH : VEC_LOW))
    else $error("reset vector");
  AST_STOP_SHORT: assert property (stop_exit
    && operating_mode_reg[OMR_SD_BIT] |-> ##17 stop_wake) else $error("stop");
endmodule
bind pscm_core pscm_checker #(.STOP_LONG(STOP_LONG)) u_chk (.*);

// ===== tb/pscm_core_tb.sv
// self-checking bench for the stack and mode control block
`timescale 1ns/1ps
module pscm_core_tb;
  import pscm_pkg::*;
  typedef struct packed {logic de; logic [15:0] a; pscm_map_t p, x, y;} pscm_row_t;
  localparam pscm_map_t E = PSCM_MAP_EXT, R = PSCM_MAP_RAM;
  localparam pscm_map_t O = PSCM_MAP_ROM, P = PSCM_MAP_PERIPH;
  localparam pscm_op_t NOP = PSCM_OP_NONE;
  localparam logic [7:0] S_OP = 8'h80, S_ABT = 8'h40, S_VEC = 8'h20;
  localparam logic [7:0] S_HW = 8'h18, S_SP = 8'h04, S_OM = 8'h02;
  pscm_row_t rows [8] = '{'{1'b0, 16'h0100, R, E, E},
    '{1'b0, 16'h0200, E, E, E}, '{1'b0, 16'hffc0, E, P, E},
    '{1'b0, 16'h00ff, R, R, R}, '{1'b1, 16'h0100, R, O, O},
    '{1'b1, 16'h01ff, R, O, O}, '{1'b1, 16'h0200, E, E, E},
    '{1'b1, 16'hffbf, E, E, E}};
  logic sys_clk = 1'b0, srst = 1'b1, want = 1'b1, bus_pin_drive = 1'b1;
  logic chip_mode_lo = 1'b0, chip_mode_hi = 1'b1, boot_done = 1'b0;
  logic [7:0] stb = 8'h00;
  logic [3:0] vw = 4'h0;
  logic [15:0] addr = 16'h0000;
  logic [31:0] d = 32'h0;
  pscm_op_t op = PSCM_OP_NONE;
  int bad_count = 0, comparisons = 0, n;
  wire op_valid, loop_abort, vec_valid, ss_wr_hi, ss_wr_lo, sp_wr, omr_wr;
  wire stop_exit, bus_pin_in, restore_pc, restore_sr, long_irq, fast_irq;
  wire vec_word0_call = vw[3], vec_word1_call = vw[2];
  wire vec_word0_flow = vw[1], vec_word1_flow = vw[0];
  wire [15:0] prog_addr = addr, xdata_addr = addr, ydata_addr = addr;
  wire [15:0] ss_wdata = d[15:0], stack_upper_half, stack_lower_half;
  wire [15:0] reset_vector;
  wire [5:0] sp_wdata = d[5:0], stack_top_pointer;
  wire [4:0] omr_wdata = d[4:0], operating_mode_reg;
  wire pscm_ctx_t ctx_in = d, ctx_out;
  wire pscm_loop_t loop_in = d, loop_regs;
  wire pscm_map_t prog_map, xdata_map, ydata_map;
  wire stop_wake, bus_request_in, wait_request_in, bus_grant_out;
  wire bus_strobe_out;
  assign {op_valid, loop_abort, vec_valid, ss_wr_hi, ss_wr_lo, sp_wr, omr_wr,
    stop_exit} = stb;
  // short stop count keeps the run brief
  pscm_core #(.STOP_LONG(40)) i_dut (.*);
  pscm_bus_partner i_far (.sys_clk(sys_clk), .want(want),
    .bus_pin_in(bus_pin_in));
  task automatic go(input logic [7:0] s, input pscm_op_t o,
    input logic [31:0] v);
    @(posedge sys_clk);
    stb <= s;
    op <= o;
    d <= v;
    @(posedge sys_clk);
    stb <= 8'h00;
    #1;
  endtask
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: %h vs %h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial forever #2.5 sys_clk = ~sys_clk;
  initial begin
    #50000;
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk({operating_mode_reg, reset_vector}, {5'h02, VEC_HIGH});
    chk(stack_top_pointer, 6'h00);
    foreach (rows[i]) begin
      go(S_OM, NOP, {29'h0, rows[i].de, 2'h2});
      @(posedge sys_clk);
      addr <= rows[i].a;
      repeat (3) @(posedge sys_clk);
      #1;
      chk(prog_map, rows[i].p);
      chk({xdata_map, ydata_map}, {rows[i].x, rows[i].y});
    end
    @(posedge sys_clk);
    addr <= 16'h0000;
    for (int m = 0; m < 4; m += 3) begin
      go(S_OM, NOP, m);
      repeat (4) @(posedge sys_clk);
      #1;
      chk({prog_map, reset_vector}, {m ? E : R, VEC_LOW});
    end
    go(S_OM, NOP, 32'h01);
    @(posedge sys_clk);
    boot_done <= 1'b1;
    @(posedge sys_clk);
    boot_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(operating_mode_reg, 5'h02);
    $display("done reset and maps");
    go(S_OP, PSCM_OP_CALL, 32'h1111_2222);
    @(posedge sys_clk);
    #1;
    chk({stack_top_pointer, stack_upper_half, stack_lower_half},
      {6'h01, 32'h1111_2222});
    go(S_HW, NOP, 32'h0000_abcd);
    @(posedge sys_clk);
    #1;
    chk({stack_upper_half, stack_lower_half}, 32'habcd_abcd);
    go(S_OP, PSCM_OP_LOOP, 32'h0005_0100);
    chk(loop_regs, 32'h0005_0100);
    go(S_OP, PSCM_OP_LOOP, 32'h0007_0200);
    go(S_ABT, NOP, 32'h0);
    chk(loop_regs, 32'h0005_0100);
    go(S_OP, PSCM_OP_LOOPEND, 32'h0);
    chk(stack_top_pointer, 6'h01);
    go(S_OP, PSCM_OP_RTS, 32'h0);
    chk({restore_pc, restore_sr, ctx_out}, {2'b10, 32'habcd_abcd});
    chk(stack_top_pointer, 6'h00);
    go(S_OP, PSCM_OP_RTS, 32'h0);
    chk(stack_top_pointer[SP_UF_BIT], 1'b1);
    go(S_SP, NOP, 32'h0);
    chk(stack_top_pointer, 6'h00);
    go(S_OP, PSCM_OP_CALL, 32'h3333_4444);
    go(S_OP, PSCM_OP_RTI, 32'h0);
    chk({restore_pc, restore_sr, ctx_out}, {2'b11, 32'h3333_4444});
    for (int k = 0; k < 16; k++) go(S_OP, PSCM_OP_CALL, k);
    chk(stack_top_pointer[4:0], 5'h1f);
    go(S_SP, NOP, 32'h0);
    go(S_VEC, NOP, 32'h0);
    chk({long_irq, fast_irq, stack_top_pointer}, {2'b01, 6'h00});
    @(posedge sys_clk);
    vw <= 4'h4;
    go(S_VEC, NOP, 32'h3333_4444);
    chk({long_irq, fast_irq, stack_top_pointer}, {2'b10, 6'h01});
    $display("done stack");
    for (int k = 0; k < 2; k++) begin
      go(S_OM, NOP, k ? 32'h0a : 32'h02);
      go(8'h01, NOP, 32'h0);
      n = 1;
      while (stop_wake !== 1'b1 && n < 100) begin
        @(posedge sys_clk);
        #1;
        n++;
      end
      chk(n, k ? 17 : 40);
      go(S_OM, NOP, k ? 32'h12 : 32'h02);
      repeat (5) @(posedge sys_clk);
      #1;
      chk({bus_request_in, wait_request_in, bus_grant_out, bus_strobe_out},
        k ? 4'h5 : 4'ha);
      @(posedge sys_clk);
      want <= 1'b0;
      repeat (5) @(posedge sys_clk);
      #1;
      chk({bus_request_in, wait_request_in, bus_grant_out, bus_strobe_out},
        k ? 4'h1 : 4'h2);
      @(posedge sys_clk);
      want <= 1'b1;
    end
    $display("done modes");
    finish_test();
  end
endmodule
